/* File: rtl/fcr_regs.svh */
`ifndef FCR_REGS_SVH
`define FCR_REGS_SVH

// register addresses on the register port
`define FCR_CTRL0_ADDR 16'h0fe0
`define FCR_CTRL1_ADDR 16'h0fe1
`define FCR_CTRL2_ADDR 16'h0fe2

// control register 0 fields
`define FCR_C0_READY 0
`define FCR_C0_REWRITE 1
`define FCR_C0_SMALL 2
`define FCR_C0_FRESET 3
`define FCR_C0_PERR 6
`define FCR_C0_EERR 7

// control register 1 fields
`define FCR_C1_SUS_EN 0
`define FCR_C1_SUS_REQ 1
`define FCR_C1_SUS_FLAG 6

// control register 2 fields
`define FCR_C2_HOLD 1
`define FCR_C2_ALL 4

// reset value of the register port read data
`define FCR_REG_RESET 8'h00

// software command codes
`define FCR_CMD_READ_ARRAY 8'hff
`define FCR_CMD_READ_STATUS 8'h70
`define FCR_CMD_CLEAR_STATUS 8'h50
`define FCR_CMD_PROGRAM 8'h40
`define FCR_CMD_ERASE 8'h20
`define FCR_CMD_ERASE_CONFIRM 8'hd0

// status register fields
`define FCR_SR_READY 7
`define FCR_SR_EERR 5
`define FCR_SR_PERR 4

// start vector location, same address in either start area
`define FCR_START_VECTOR 16'hfffc

// timing
`define FCR_CLK_PERIOD_NS 50
`define FCR_SUSPEND_LATENCY_NS 20000
`define FCR_SUSPEND_CYCLES (`FCR_SUSPEND_LATENCY_NS / `FCR_CLK_PERIOD_NS)

`endif

/* File: rtl/fcr_pkg.sv */
package fcr_pkg;

    typedef enum logic [2:0] {
        ST_ARRAY = 3'b000,
        ST_STATUS = 3'b001,
        ST_PROG_ARG = 3'b010,
        ST_ERASE_ARG = 3'b011,
        ST_BUSY = 3'b100
    } fcr_cmd_state_t;

endpackage

/* File: rtl/fcr_block_decode.sv */
`timescale 1ns/1ps

module fcr_block_decode (
    // address to classify
    input wire logic [15:0] addr,
    // protection enables
    input wire logic all_en,
    input wire logic small_en,
    // results
    output logic in_user,
    output logic at_top,
    output logic writable
);

    wire logic is_small = addr[15:14] == 2'h3;
    wire logic is_mid = addr[15:14] == 2'h2 || addr[15:14] == 2'h1;
    wire logic is_data = addr[15:12] == 4'h1;

    assign in_user = is_small | is_mid | is_data;

    assign at_top = is_small ? (&addr[12:0]) :
                    is_mid ? (&addr[13:0]) :
                    is_data ? (&addr[10:0]) : 1'b0;

    assign writable = is_data | (is_mid & all_en) |
                      (is_small & all_en & small_en);

endmodule

/* File: rtl/fcr_rewrite_ctrl.sv */
`timescale 1ns/1ps
`include "fcr_regs.svh"
// Overview of operation
// - rewrite touches user area only, never boot
// - executing mode blocks CPU flash fetches
// - boot select low starts normal mode
// - both straps high start boot mode
// - erase names block by top address
// - after operation: status or array mode
// - hold mode holds CPU while busy and not suspended
// - executing mode reports flags and status
// - rewrite set forces executing mode
// - rewrite bit sets only after zero write
// - software suspend, wait latency, check flag
// - clearing request resumes erase
// - hold mode interrupt sets suspend request
// - latency later suspend, interrupt accepted
// - small enable permits blocks zero, one
// - ready flag zero while operating
// - rewrite select at control zero bit one
module fcr_rewrite_ctrl (
    // clock, reset, enable
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    // register port
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata_q,
    // software command port
    input wire logic [15:0] cmd_addr,
    input wire logic [7:0] cmd_wdata,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    output logic [7:0] cmd_rdata_q,
    // interrupt path
    input wire logic irq_req,
    output logic irq_accept_q,
    // flash array macro
    output logic mac_prog_q,
    output logic mac_erase_q,
    output logic [15:0] mac_addr_q,
    output logic [7:0] mac_wdata_q,
    output logic mac_suspend_q,
    input wire logic mac_done,
    input wire logic mac_fail,
    input wire logic [7:0] mac_rdata,
    // cpu control
    output logic cpu_hold_q,
    output logic cpu_fetch_block_q,
    // start straps
    input wire logic boot_select_pin,
    input wire logic boot_serial_receive_pin,
    output logic boot_mode_q,
    output logic start_valid_q,
    output logic [15:0] start_vector_q
);

    localparam int SUS_CYC = `FCR_SUSPEND_CYCLES;

    function automatic logic pair_set(input logic cur, input logic armed,
                                      input logic wr, input logic wbit);
        logic r;
        r = cur;
        if (wr)
        begin
            r = wbit & (cur | armed);
        end
        return r;
    endfunction

    function automatic fcr_pkg::fcr_cmd_state_t after_op(input logic hold);
        return hold ? fcr_pkg::ST_ARRAY : fcr_pkg::ST_STATUS;
    endfunction

    logic rewrite_q, hold_q, small_q, freset_q, all_q;
    logic sus_en_q, sus_req_q, suspended_q;
    logic arm0_q, arm1_q, arm2_q;
    logic busy_q, erase_op_q, perr_q, eerr_q, boot_done_q;
    logic [8:0] lat_q;
    fcr_pkg::fcr_cmd_state_t st_q, st_d;
    logic dec_in_user, dec_at_top, dec_writable;

    fcr_block_decode u_decode (
        .addr(cmd_addr),
        .all_en(all_q),
        .small_en(small_q),
        .in_user(dec_in_user),
        .at_top(dec_at_top),
        .writable(dec_writable)
    );

    // register write decode
    wire logic any_wr = ce & reg_wr;
    wire logic wr0 = any_wr & (reg_addr == `FCR_CTRL0_ADDR);
    wire logic wr1 = any_wr & (reg_addr == `FCR_CTRL1_ADDR);
    wire logic wr2 = any_wr & (reg_addr == `FCR_CTRL2_ADDR);
    wire logic ctl_reset = rewrite_q & freset_q;

    wire logic rewrite_d = pair_set(rewrite_q, arm0_q, wr0,
                                    reg_wdata[`FCR_C0_REWRITE]);
    wire logic hold_d = (rewrite_d & rewrite_q) ?
        pair_set(hold_q, arm2_q, wr2, reg_wdata[`FCR_C2_HOLD]) : 1'b0;
    wire logic sus_en_d = pair_set(sus_en_q, arm1_q, wr1,
                                   reg_wdata[`FCR_C1_SUS_EN]);

    // command decode; commands only count in rewrite mode
    wire logic cmd_ok = ce & cmd_wr & rewrite_q & ~freset_q;
    wire logic idle_cmd = cmd_ok &
        (st_q == fcr_pkg::ST_ARRAY || st_q == fcr_pkg::ST_STATUS);
    wire logic clr_status = idle_cmd &
        (cmd_wdata == `FCR_CMD_CLEAR_STATUS);
    wire logic in_prog_arg = st_q == fcr_pkg::ST_PROG_ARG;
    wire logic in_erase_arg = st_q == fcr_pkg::ST_ERASE_ARG;
    wire logic prog_go = cmd_ok & in_prog_arg & dec_writable;
    wire logic prog_bad = cmd_ok & in_prog_arg & ~dec_writable;
    wire logic erase_go = cmd_ok & in_erase_arg & dec_at_top &
        dec_writable & (cmd_wdata == `FCR_CMD_ERASE_CONFIRM);
    wire logic erase_bad = cmd_ok & in_erase_arg & ~erase_go;

    // operation tracking
    wire logic erasing = busy_q & erase_op_q;
    wire logic op_done = ce & busy_q & mac_done & ~ctl_reset;
    wire logic op_fail = op_done & mac_fail;
    wire logic busy_d = ~ctl_reset &
        (prog_go | erase_go | (busy_q & ~op_done));
    wire logic erase_op_d = erase_go | (erase_op_q & ~prog_go);
    // error flags: a new error beats a clear in the same cycle
    wire logic perr_d = prog_bad | (op_fail & ~erase_op_q) |
        (perr_q & ~clr_status & ~ctl_reset);
    wire logic eerr_d = erase_bad | (op_fail & erase_op_q) |
        (eerr_q & ~clr_status & ~ctl_reset);

    wire logic sw_set = wr1 & reg_wdata[`FCR_C1_SUS_REQ] & sus_en_q;
    wire logic sw_clr = wr1 & ~reg_wdata[`FCR_C1_SUS_REQ];
    wire logic auto_set = ce & irq_req & hold_q & sus_en_q & erasing;
    wire logic sus_req_d = erasing & ~op_done & ~ctl_reset &
        (auto_set | sw_set | (sus_req_q & ~sw_clr));
    wire logic lat_run = sus_req_q & ~suspended_q;
    wire logic lat_hit = lat_run & (lat_q == 9'(SUS_CYC - 1));
    wire logic suspended_d = sus_req_d & (suspended_q | lat_hit);
    wire logic [8:0] lat_d = lat_run ? lat_q + 9'h001 : 9'h000;

    // read paths
    // flags and status bits
    wire logic [7:0] ctrl0_rd = {eerr_q, perr_q, 2'h0, freset_q,
                                 small_q, rewrite_q, ~busy_q};
    wire logic [7:0] ctrl1_rd = {1'b0, suspended_q, 4'h0,
                                 sus_req_q, sus_en_q};
    wire logic [7:0] ctrl2_rd = {3'h0, all_q, 2'h0, hold_q, 1'b0};
    wire logic [7:0] reg_mux =
        (reg_addr == `FCR_CTRL0_ADDR) ? ctrl0_rd :
        (reg_addr == `FCR_CTRL1_ADDR) ? ctrl1_rd :
        (reg_addr == `FCR_CTRL2_ADDR) ? ctrl2_rd : 8'h00;
    wire logic [7:0] status_byte = {~busy_q, 1'b0, eerr_q, perr_q, 4'h0};
    // a suspended erase frees the array for reads
    wire logic show_status = (st_q == fcr_pkg::ST_STATUS) ||
        (st_q == fcr_pkg::ST_BUSY && !suspended_q);
    wire logic [7:0] cmd_mux = show_status ? status_byte : mac_rdata;
    wire logic boot_strap = boot_select_pin & boot_serial_receive_pin;

    always_comb
    begin
        st_d = st_q;
        unique case (st_q)
            fcr_pkg::ST_ARRAY, fcr_pkg::ST_STATUS:
            begin
                if (idle_cmd && cmd_wdata == `FCR_CMD_READ_ARRAY)
                begin
                    st_d = fcr_pkg::ST_ARRAY;
                end
                else if (idle_cmd && !hold_q &&
                         cmd_wdata == `FCR_CMD_READ_STATUS)
                begin
                    st_d = fcr_pkg::ST_STATUS;
                end
                else if (idle_cmd && cmd_wdata == `FCR_CMD_PROGRAM)
                begin
                    st_d = fcr_pkg::ST_PROG_ARG;
                end
                else if (idle_cmd && cmd_wdata == `FCR_CMD_ERASE)
                begin
                    st_d = fcr_pkg::ST_ERASE_ARG;
                end
            end
            fcr_pkg::ST_PROG_ARG, fcr_pkg::ST_ERASE_ARG:
            begin
                if (prog_go || erase_go)
                begin
                    st_d = fcr_pkg::ST_BUSY;
                end
                else if (prog_bad || erase_bad)
                begin
                    st_d = after_op(hold_q);
                end
            end
            fcr_pkg::ST_BUSY:
            begin
                if (op_done)
                begin
                    st_d = after_op(hold_q);
                end
            end
            default:
            begin
                st_d = fcr_pkg::ST_ARRAY;
            end
        endcase
        if (!rewrite_q || ctl_reset)
        begin
            st_d = fcr_pkg::ST_ARRAY;
        end
    end

    // control bits; a write elsewhere breaks a zero-then-one pair
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            {rewrite_q, hold_q, small_q, freset_q} <= 4'h0;
            {all_q, sus_en_q, arm0_q, arm1_q, arm2_q} <= 5'h00;
        end
        else if (ce)
        begin
            rewrite_q <= rewrite_d;
            hold_q <= hold_d;
            sus_en_q <= sus_en_d;
            if (any_wr)
            begin
                arm0_q <= wr0 & ~reg_wdata[`FCR_C0_REWRITE];
                arm1_q <= wr1 & ~reg_wdata[`FCR_C1_SUS_EN];
                arm2_q <= wr2 & ~reg_wdata[`FCR_C2_HOLD];
            end
            if (wr0)
            begin
                small_q <= reg_wdata[`FCR_C0_SMALL];
                freset_q <= reg_wdata[`FCR_C0_FRESET];
            end
            if (wr2)
            begin
                all_q <= reg_wdata[`FCR_C2_ALL];
            end
        end
    end

    // operation and suspend state
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_q <= fcr_pkg::ST_ARRAY;
            {busy_q, erase_op_q, perr_q, eerr_q} <= 4'h0;
            {sus_req_q, suspended_q} <= 2'h0;
            lat_q <= 9'h000;
        end
        else if (ce)
        begin
            st_q <= st_d;
            busy_q <= busy_d;
            erase_op_q <= erase_op_d;
            perr_q <= perr_d;
            eerr_q <= eerr_d;
            sus_req_q <= sus_req_d;
            suspended_q <= suspended_d;
            lat_q <= lat_d;
        end
    end

    // registered outputs
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            reg_rdata_q <= `FCR_REG_RESET;
            cmd_rdata_q <= 8'h00;
            {mac_prog_q, mac_erase_q, mac_suspend_q} <= 3'h0;
            mac_addr_q <= 16'h0000;
            mac_wdata_q <= 8'h00;
            {cpu_hold_q, cpu_fetch_block_q, irq_accept_q} <= 3'h0;
        end
        else if (ce)
        begin
            reg_rdata_q <= reg_rd ? reg_mux : 8'h00;
            cmd_rdata_q <= cmd_rd ? cmd_mux : 8'h00;
            mac_prog_q <= prog_go;
            mac_erase_q <= erase_go;
            if (prog_go || erase_go)
            begin
                mac_addr_q <= cmd_addr;
                mac_wdata_q <= cmd_wdata;
            end
            mac_suspend_q <= sus_req_d;
            cpu_hold_q <= hold_d & busy_d & ~suspended_d;
            cpu_fetch_block_q <= rewrite_d & ~hold_d;
            irq_accept_q <= lat_hit & hold_d & sus_req_d;
        end
    end

    // straps are caught on the first enabled edge after release
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            {boot_done_q, boot_mode_q, start_valid_q} <= 3'h0;
            start_vector_q <= 16'h0000;
        end
        else if (ce && !boot_done_q)
        begin
            boot_done_q <= 1'b1;
            boot_mode_q <= boot_strap;
            start_valid_q <= 1'b1;
            start_vector_q <= `FCR_START_VECTOR;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_req_start;
        $rose(sus_req_q) && !suspended_q;
    endsequence
    sequence s_still_waiting;
        !suspended_q [*8];
    endsequence

    chk_prog_user_only: assert property (
        (cmd_ok && in_prog_arg && !dec_in_user) |=> !mac_prog_q && perr_q)
        else $error("program outside user area started");
    chk_cpu_fetch: assert property (
        cpu_fetch_block_q == (rewrite_q && !hold_q))
        else $error("fetch block does not follow mode");
    chk_boot_strap: assert property (
        $rose(start_valid_q) |-> boot_mode_q == $past(boot_strap))
        else $error("start area does not match straps");
    chk_erase_top: assert property (
        (cmd_ok && in_erase_arg && !dec_at_top) |=> !mac_erase_q && eerr_q)
        else $error("erase started without top address");
    chk_hold_after_op: assert property (
        (op_done && rewrite_q && hold_q) |=> st_q == fcr_pkg::ST_ARRAY)
        else $error("hold mode not in array mode after op");
    chk_exec_after_op: assert property (
        (op_done && rewrite_q && !hold_q) |=> st_q == fcr_pkg::ST_STATUS)
        else $error("executing mode not in status mode after op");
    chk_cpu_held: assert property (
        cpu_hold_q == (hold_q && busy_q && !suspended_q))
        else $error("cpu hold does not follow operation");
    chk_rewrite_forces_exec: assert property (
        $rose(rewrite_q) |-> !hold_q)
        else $error("hold mode survived rewrite entry");
    chk_rewrite_pair: assert property (
        (wr0 && reg_wdata[1] && !arm0_q && !rewrite_q) |=> !rewrite_q)
        else $error("rewrite set without zero write first");
    chk_suspend_wait: assert property (
        s_req_start |-> s_still_waiting)
        else $error("suspend flag rose too early");
    chk_resume_erase: assert property (
        (sus_req_q && sw_clr && !auto_set) |=> !mac_suspend_q && !suspended_q)
        else $error("erase not resumed on request clear");
    chk_auto_request: assert property (
        (auto_set && !op_done && !ctl_reset) |=> sus_req_q && mac_suspend_q)
        else $error("interrupt did not raise suspend request");
    chk_suspend_latency: assert property (
        $rose(suspended_q) |-> $past(lat_q) == SUS_CYC - 1)
        else $error("suspend latency count wrong");
    chk_irq_accept: assert property (
        irq_accept_q |-> suspended_q && hold_q)
        else $error("interrupt accepted before suspend");
    chk_ready_flag: assert property (
        (ce && reg_rd && reg_addr == `FCR_CTRL0_ADDR) |=>
            reg_rdata_q[0] == !$past(busy_q))
        else $error("ready flag wrong");

endmodule

/* File: bench/fcr_mac_model.sv */
`timescale 1ns/1ps
module fcr_mac_model #(
    parameter int DUR = 600
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // starts from the sequencer
    input wire logic prog,
    input wire logic erase,
    input wire logic suspend,
    input wire logic fail_en,
    input wire logic [15:0] addr,
    // answers
    output logic done,
    output logic fail,
    output logic [7:0] rdata
);
    int cnt;
    logic busy;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt <= 0;
            busy <= 1'b0;
            done <= 1'b0;
            fail <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            // fail only means something beside done, so it wanders
            fail <= ~fail;
            if (prog || erase)
            begin
                cnt <= DUR;
                busy <= 1'b1;
            end
            else if (busy && !suspend)
            begin
                cnt <= cnt - 1;
                if (cnt == 1)
                begin
                    done <= 1'b1;
                    fail <= fail_en;
                    busy <= 1'b0;
                end
            end
        end
    end
    assign rdata = addr[7:0] ^ addr[15:8] ^ 8'ha5;
endmodule

/* File: bench/tb.sv */
`timescale 1ns/1ps
`include "fcr_regs.svh"
module tb;
    localparam logic [15:0] C0 = `FCR_CTRL0_ADDR;
    localparam logic [15:0] C1 = `FCR_CTRL1_ADDR;
    localparam logic [15:0] C2 = `FCR_CTRL2_ADDR;
    logic clk, reset_n, ce, reg_wr, reg_rd, cmd_wr, cmd_rd, irq_req;
    logic boot_select_pin, boot_serial_receive_pin, fail_en;
    logic irq_accept_q, mac_prog_q, mac_erase_q, mac_suspend_q;
    logic mac_done, mac_fail, cpu_hold_q, cpu_fetch_block_q;
    logic boot_mode_q, start_valid_q;
    logic [15:0] reg_addr, cmd_addr, mac_addr_q, start_vector_q, a;
    logic [7:0] reg_wdata, cmd_wdata, reg_rdata_q, cmd_rdata_q;
    logic [7:0] mac_wdata_q, mac_rdata, rr, cr, d;
    logic [4:0] fl;
    int n_errors, n_tests, seed, cyc, n_done, n_prog, n_acc, k, o;

    fcr_rewrite_ctrl dut_u (.clk, .reset_n, .ce, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata_q, .cmd_addr, .cmd_wdata, .cmd_wr,
        .cmd_rd, .cmd_rdata_q, .irq_req, .irq_accept_q, .mac_prog_q,
        .mac_erase_q, .mac_addr_q, .mac_wdata_q, .mac_suspend_q,
        .mac_done, .mac_fail, .mac_rdata, .cpu_hold_q, .cpu_fetch_block_q,
        .boot_select_pin, .boot_serial_receive_pin, .boot_mode_q,
        .start_valid_q, .start_vector_q);
    fcr_mac_model #(.DUR(600)) mac_u (.clk(clk), .reset_n(reset_n),
        .prog(mac_prog_q), .erase(mac_erase_q), .suspend(mac_suspend_q),
        .fail_en(fail_en), .addr(cmd_addr), .done(mac_done),
        .fail(mac_fail), .rdata(mac_rdata));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task close_out;
        if (n_errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            close_out;
        end
    end

    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one bus cycle; samples what the previous cycle produced
    task op(input int kd, input logic [15:0] ad, input logic [7:0] dt);
        reg_wr <= (kd == 0);
        reg_rd <= (kd == 1);
        cmd_wr <= (kd == 2);
        cmd_rd <= (kd == 3);
        reg_addr <= ad;
        cmd_addr <= ad;
        reg_wdata <= dt;
        cmd_wdata <= dt;
        @(negedge clk);
        rr = reg_rdata_q;
        cr = cmd_rdata_q;
        fl = {mac_suspend_q, cpu_hold_q, cpu_fetch_block_q, boot_mode_q,
            start_valid_q};
        n_done += int'(mac_done);
        n_prog += int'(mac_prog_q);
        n_acc += int'(irq_accept_q);
        @(posedge clk);
    endtask

    task rdc(input logic [15:0] ad, input logic [7:0] ex);
        op(1, ad, 8'h00);
        op(4, 16'h0000, 8'h00);
        chk(16'(rr), 16'(ex));
    endtask

    task waitd;
        o = n_done;
        for (k = 0; k < 2000 && n_done == o; k++)
            op(4, 16'h0000, 8'h00);
        chk(16'(n_done - o), 16'h0001);
    endtask

    task erase(input logic [15:0] ad);
        op(2, 16'h0000, `FCR_CMD_ERASE);
        op(2, ad, `FCR_CMD_ERASE_CONFIRM);
        op(4, 16'h0000, 8'h00);
        op(4, 16'h0000, 8'h00);
    endtask

    task rst(input logic [1:0] st);
        @(posedge clk);
        reset_n <= 1'b0;
        boot_select_pin <= st[1];
        boot_serial_receive_pin <= st[0];
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        op(4, 16'h0000, 8'h00);
        op(4, 16'h0000, 8'h00);
        chk(16'(fl[1:0]), {14'h0, st == 2'b11, 1'b1});
        chk(start_vector_q, `FCR_START_VECTOR);
    endtask

    function automatic logic [7:0] c0v(logic e, logic p, logic s,
        logic w, logic r);
        return {e, p, 3'b000, s, w, r};
    endfunction

    initial
    begin
        {reset_n, reg_wr, reg_rd, cmd_wr, cmd_rd, irq_req, fail_en} = '0;
        {boot_select_pin, boot_serial_receive_pin} = '0;
        {reg_addr, cmd_addr, reg_wdata, cmd_wdata} = '0;
        ce = 1'b1;
        seed = 52;
        for (int i = 0; i < 4; i++)
            rst(2'(i));
        rdc(C0, 8'h01);
        rdc(C1, 8'h00);
        rdc(C2, 8'h00);
        rdc(16'h0fe5, 8'h00);
        // a lone write of one must not open rewrite mode
        op(0, C0, 8'h02);
        rdc(C0, 8'h01);
        op(0, C0, 8'h00);
        op(0, C0, 8'h02);
        rdc(C0, 8'h03);
        chk(16'(fl[2]), 16'h0001);
        // a frozen block ignores a write that would clear rewrite
        ce <= 1'b0;
        op(0, C0, 8'h00);
        op(4, 16'h0000, 8'h00);
        ce <= 1'b1;
        rdc(C0, 8'h03);
        op(0, C2, 8'h00);
        op(0, C2, 8'h02);
        rdc(C2, 8'h02);
        op(0, C0, 8'h00);
        op(0, C0, 8'h02);
        rdc(C2, 8'h00);
        op(0, C2, 8'h10);
        op(0, C0, 8'h06);
        for (int i = 0; i < 3; i++)
        begin
            a = 16'($random(seed));
            a = i == 0 ? 16'h1000 | (a & 16'h0fff) :
                i == 1 ? 16'hc000 | (a & 16'h3fff) : 16'h2abc;
            d = 8'($random(seed));
            fail_en <= (i == 1);
            op(2, 16'h0000, `FCR_CMD_PROGRAM);
            op(2, a, d);
            if (i < 2)
            begin
                rdc(C0, c0v(0, 0, 1, 1, 0));
                chk({d, 8'h00} | 16'(mac_addr_q == a), {mac_wdata_q, 8'h01});
                waitd;
                op(3, a, 8'h00);
                op(4, 16'h0000, 8'h00);
                chk(16'(cr), {8'h00, 3'b100, i == 1, 4'h0});
                rdc(C0, c0v(0, i == 1, 1, 1, 1));
            end
            else
                rdc(C0, c0v(0, 1, 1, 1, 1));
            op(2, 16'h0000, `FCR_CMD_CLEAR_STATUS);
        end
        op(2, 16'h0000, `FCR_CMD_READ_ARRAY);
        op(3, 16'h1234, 8'h00);
        op(2, 16'h0000, `FCR_CMD_READ_STATUS);
        chk(16'(cr), 16'h0083);
        op(3, 16'h1234, 8'h00);
        op(4, 16'h0000, 8'h00);
        chk(16'(cr), 16'h0080);
        chk(16'(n_prog), 16'h0002);
        erase(16'h17fe);
        rdc(C0, c0v(1, 0, 1, 1, 1));
        op(2, 16'h0000, `FCR_CMD_CLEAR_STATUS);
        op(0, C1, 8'h00);
        op(0, C1, 8'h01);
        erase(16'h17ff);
        chk(mac_addr_q, 16'h17ff);
        op(0, C1, 8'h03);
        op(4, 16'h0000, 8'h00);
        chk(16'(fl[4]), 16'h0001);
        rdc(C1, 8'h03);
        repeat (400) op(4, 16'h0000, 8'h00);
        rdc(C1, 8'h43);
        op(0, C1, 8'h01);
        op(4, 16'h0000, 8'h00);
        chk(16'(fl[4]), 16'h0000);
        waitd;
        rdc(C1, 8'h01);
        op(0, C2, 8'h10);
        op(0, C2, 8'h12);
        rdc(C2, 8'h12);
        erase(16'h1fff);
        chk(16'(fl[3]), 16'h0001);
        // the interrupt itself must raise the request
        irq_req <= 1'b1;
        o = n_acc;
        for (k = 0; k < 600 && n_acc == o; k++)
            op(4, 16'h0000, 8'h00);
        chk(16'(k >= 396 && k <= 404), 16'h0001);
        irq_req <= 1'b0;
        op(4, 16'h0000, 8'h00);
        chk(16'(fl[4:3]), 16'h0002);
        rdc(C1, 8'h43);
        op(0, C1, 8'h01);
        // a second erase while still busy must not restart the block
        erase(16'h1fff);
        waitd;
        rdc(C0, c0v(0, 0, 1, 1, 1));
        op(2, 16'h0000, `FCR_CMD_READ_STATUS);
        op(3, 16'h1234, 8'h00);
        op(4, 16'h0000, 8'h00);
        chk(16'(cr), 16'h0083);
        // flash reset aborts a running program and frees the flag
        op(2, 16'h0000, `FCR_CMD_PROGRAM);
        op(2, 16'h1100, 8'h5a);
        op(0, C0, 8'h0e);
        op(4, 16'h0000, 8'h00);
        rdc(C0, 8'h0f);
        close_out;
    end
endmodule
